// File: testbench/acquisition_run_control_bench.sv
// Self-checking bench for the acquisition run control block
`timescale 1ns/10ps
`include "arc_map.svh"
module acquisition_run_control_bench;
  logic        clk_sys, srst, adc_valid, trig_in, relay_fitted, mem0_we, mem1_we, irq;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [20:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, dig_wide, rd_d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [63:0] adc_data;
  logic [15:0] dig_in, mem0_data, mem1_data;
  logic [26:0] mem0_addr, mem1_addr;
  int          error_cnt = 0, n_compared = 0, i;
  localparam logic [18:0] ST = `ARC_IDX_RUN_STATE;
  arc_run_control #(.MS_CYCLES(10)) u_arc_run_control (.clk_sys, .srst, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .adc_valid, .adc_data, .dig_in,
    .dig_wide, .trig_in, .relay_fitted, .mem0_we, .mem0_addr, .mem0_data, .mem1_we,
    .mem1_addr, .mem1_data, .irq);
  arc_host u_arc_host (.clk_sys, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [18:0] x, input logic [31:0] d);
    @(posedge clk_sys);
    u_arc_host.wr({x, 2'h0}, d, rsp);
    chk(!u_arc_host.hung && rsp === `ARC_RESP_OKAY, "write response");
    if (u_arc_host.hung) end_sim();
  endtask
  task automatic rx(input logic [18:0] x, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk_sys);
    u_arc_host.rd({x, 2'h0}, rd_d, rsp);
    chk(!u_arc_host.hung && rd_d === e && rsp === er, "read value");
    if (u_arc_host.hung) end_sim();
  endtask
  // One sample set; each memory word checked against its packing
  task automatic samp(input logic [63:0] ad, input int nch, input int idx, input logic [1:0] md);
    int s, n;
    logic [15:0] w;
    @(posedge clk_sys);
    adc_valid <= 1'b1;
    adc_data  <= ad;
    @(posedge clk_sys);
    adc_valid <= 1'b0;
    @(negedge clk_sys);
    if (md == 2'h3) chk(mem1_we === 1'b1 && mem1_addr === 27'(idx) &&
                        mem1_data === dig_wide[31:16], "second group");
    for (s = 0; s < nch; s++) begin
      n = 0;
      do begin
        @(negedge clk_sys);
        n++;
      end while (mem0_we !== 1'b1 && n < 8);
      w = (md == 2'h1) ? {dig_in[4*s +: 4], ad[16*s+4 +: 12]} :
          (md == 2'h2) ? {dig_in[4*s +: 2], ad[16*s+2 +: 14]} :
          (md == 2'h3 && s == nch - 1) ? dig_wide[15:0] : ad[16*s +: 16];
      chk(mem0_addr === 27'(idx * nch + s) && mem0_data === w, "sample word");
      if (n >= 8) end_sim();
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    {srst, adc_valid, trig_in, relay_fitted} = 4'h8;
    adc_data = 64'h0;
    dig_in = 16'hA5C3;
    dig_wide = 32'h0;
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    rx(ST, `ARC_STS_STOPPED, `ARC_RESP_OKAY);
    rx(19'h7FFFF, 32'h0, `ARC_RESP_SLVERR);
    wr(`ARC_IDX_REC_LEN, 32'h40);
    wr(`ARC_IDX_POST, 32'h20);
    wr(`ARC_IDX_CHAN_SEL, 32'h0);
    wr(`ARC_IDX_DIG_MODE, 32'h1);
    trig_in <= 1'b1;
    wr(`ARC_IDX_COMMAND, `ARC_CMD_START);
    rx(ST, `ARC_STS_ARMED, `ARC_RESP_OKAY);
    for (i = 0; i < 70; i++) begin
      samp({48'h0, 16'h8765 ^ 16'(i)}, 1, i % 64, 1'b1);
      if (i == 30) begin
        rx(ST, `ARC_STS_ARMED, `ARC_RESP_OKAY);
        trig_in <= 1'b0;
      end
    end
    @(posedge clk_sys);
    trig_in <= 1'b1;
    rx(ST, `ARC_STS_TRIG, `ARC_RESP_OKAY);
    for (i = 0; i < 32; i++) begin
      if (i == 31) rx(ST, `ARC_STS_TRIG, `ARC_RESP_OKAY);
      samp({48'h0, 16'(i * 257)}, 1, (70 + i) % 64, 1'b1);
    end
    rx(ST, `ARC_STS_STOPPED, `ARC_RESP_OKAY);
    // Interrupt start with no samples: only the wait limit can end it
    wr(`ARC_IDX_DIG_MODE, 32'h0);
    wr(`ARC_IDX_WAIT_MS, 32'h1);
    wr(`ARC_IDX_COMMAND, `ARC_CMD_START_IRQ);
    chk(irq === 1'b0, "irq early");
    for (i = 0; i < 40 && irq !== 1'b1; i++) @(negedge clk_sys);
    chk(irq === 1'b1, "timeout irq");
    rx(`ARC_IDX_FLAGS, 32'h3, `ARC_RESP_OKAY);
    rx(ST, `ARC_STS_STOPPED, `ARC_RESP_OKAY);
    wr(`ARC_IDX_FLAGS, 32'h3);
    wr(`ARC_IDX_WAIT_MS, 32'h0);
    chk(irq === 1'b0, "irq clear");
    wr(`ARC_IDX_CHAN_SEL, 32'h3);
    wr(`ARC_IDX_REC_LEN, 32'h20);
    wr(`ARC_IDX_COMMAND, `ARC_CMD_START_IRQ);
    for (i = 0; i < 32; i++) samp({16'(i), 16'h8000, 16'h7FFF, 16'h5A5A}, 4, i, 1'b0);
    rx(`ARC_IDX_FLAGS, 32'h1, `ARC_RESP_OKAY);
    chk(irq === 1'b1, "done irq");
    rx(ST, `ARC_STS_STOPPED, `ARC_RESP_OKAY);
    // Settling holds the run armed although the trigger is already high
    relay_fitted <= 1'b1;
    wr(`ARC_IDX_SETTLE, 32'h28);
    for (int m = 2; m < 4; m++) begin
      wr(`ARC_IDX_DIG_MODE, 32'(m));
      wr(`ARC_IDX_COMMAND, `ARC_CMD_START);
      rx(ST, `ARC_STS_ARMED, `ARC_RESP_OKAY);
      repeat (48) @(posedge clk_sys);
      rx(ST, `ARC_STS_TRIG, `ARC_RESP_OKAY);
      dig_wide <= 32'hC3A50F96 ^ 32'(m);
      for (i = 0; i < 32; i++) samp({4{16'(i * 97)}}, 4, i, 2'(m));
      rx(ST, `ARC_STS_STOPPED, `ARC_RESP_OKAY);
    end
    relay_fitted <= 1'b0;
    wr(`ARC_IDX_COMMAND, `ARC_CMD_START);
    rx(ST, `ARC_STS_TRIG, `ARC_RESP_OKAY);
    wr(`ARC_IDX_COMMAND, `ARC_CMD_START);
    rx(ST, `ARC_STS_TRIG, `ARC_RESP_OKAY);
    wr(`ARC_IDX_COMMAND, `ARC_CMD_STOP);
    wr(ST, 32'h0);
    rx(ST, `ARC_STS_STOPPED, `ARC_RESP_OKAY);
    end_sim();
  end
  initial begin
    repeat (90000) @(posedge clk_sys);
    error_cnt++;
    end_sim();
  end
endmodule // acquisition_run_control_bench

// File: testbench/arc_host.sv
// Register bus master standing in for the host driver
`timescale 1ns/10ps
module arc_host (
  input  wire logic        clk_sys,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic      [20:0] s_axi_awaddr,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  output logic      [31:0] s_axi_wdata,
  output logic      [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  input  wire logic [1:0]  s_axi_bresp,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  output logic      [20:0] s_axi_araddr,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp
);
  logic hung = 1'b0;
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 78'h0;
  end
  //////////////////////////////////////////////////////////////////////
  // Handshakes judged mid-cycle so the edge that takes them is known
  // setup written first
  task automatic wr(input logic [20:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    int n;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    tb = 1'b0;
    for (n = 0; n < 100 && !tb; n++) begin
      @(negedge clk_sys);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      r  = s_axi_bresp;
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    hung = hung | !tb;
  endtask
  task automatic rd(input logic [20:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    int n;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    tr = 1'b0;
    for (n = 0; n < 100 && !tr; n++) begin
      @(negedge clk_sys);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      d  = s_axi_rdata;
      r  = s_axi_rresp;
      @(posedge clk_sys);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    hung = hung | !tr;
  endtask
endmodule // arc_host

// File: verilog/arc_map.svh
// Register indices, command and status codes, limits and timing for run control
`ifndef ARC_MAP_SVH
`define ARC_MAP_SVH
`define ARC_IDX_W          19
`define ARC_IDX_COMMAND    19'h00000
`define ARC_IDX_RUN_STATE  19'h0000A
`define ARC_IDX_WAIT_MS    19'h480DA
`define ARC_IDX_REC_LEN    19'h02710
`define ARC_IDX_POST       19'h02774
`define ARC_IDX_CHAN_SEL   19'h03000
`define ARC_IDX_DIG_MODE   19'h03001
`define ARC_IDX_SETTLE     19'h03002
`define ARC_IDX_FLAGS      19'h03003
`define ARC_CMD_START      32'h0000000A
`define ARC_CMD_START_IRQ  32'h0000000B
`define ARC_CMD_STOP       32'h00000014
`define ARC_STS_ARMED      32'h00000000
`define ARC_STS_TRIG       32'h0000000A
`define ARC_STS_STOPPED    32'h00000014
`define ARC_POST_MAX_ONE   32'h08000000
`define ARC_MIN_ONE        32'h00000020
`define ARC_MIN_MULTI      32'h00000010
`define ARC_STEP_ONE       32'h00000020
`define ARC_SEL_CH0        2'h0
`define ARC_SEL_CH01       2'h1
`define ARC_SEL_CH02       2'h2
`define ARC_SEL_ALL        2'h3
`define ARC_DIG_OFF        2'h0
`define ARC_DIG_FOUR       2'h1
`define ARC_DIG_TWO        2'h2
`define ARC_DIG_REPLACE    2'h3
`define ARC_FLAG_DONE      3'h1
`define ARC_FLAG_TIMEOUT   3'h2
`define ARC_FLAG_SETUP     3'h4
`define ARC_RESP_OKAY      2'h0
`define ARC_RESP_SLVERR    2'h2
`define ARC_MS_NS          1000000
`define ARC_CLK_NS         5
`endif

// File: verilog/arc_ms_timer.sv
// Millisecond wait timer with a zero limit meaning no limit
`timescale 1ns/10ps
`include "arc_map.svh"
module arc_ms_timer #(
  parameter int MS_CYCLES = `ARC_MS_NS / `ARC_CLK_NS
) (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        run,
  input  wire logic        clear,
  input  wire logic [31:0] limit,
  output logic             expired
);
  typedef struct packed {
    logic [31:0] sub;
    logic [31:0] ms;
  } arc_tmr_t;
  arc_tmr_t st;
  arc_tmr_t next_st;
  if (MS_CYCLES < 1) begin : g_ms_check
    $error("MS_CYCLES must be at least one");
  end
  always_comb begin
    next_st = st;
    if (clear || !run) begin
      next_st = '0;
    end else if (st.sub == 32'(MS_CYCLES - 1)) begin
      next_st.sub = '0;
      next_st.ms  = st.ms + 32'h00000001;
    end else begin
      next_st.sub = st.sub + 32'h00000001;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) st <= '0;
    else      st <= next_st;
  end
  assign expired = run && (limit != 32'h00000000) && (st.ms >= limit);
endmodule // arc_ms_timer

// File: verilog/arc_pkg.sv
// Types shared by the run control block
package arc_pkg;
  typedef enum logic [2:0] {
    ARC_IDLE, ARC_SETTLE, ARC_FILL, ARC_ARMED, ARC_POST
  } arc_state_t;
  typedef logic [1:0] arc_dig_t;
endpackage

// File: verilog/arc_run_control.sv
// Acquisition run control: register slave, run state machine, sample writer
// Operation
// - Post-trigger count capped 128M/64M/32M samples
// - Pretrigger equals record length minus post count
// - Records into a ring until trigger
// - Trigger disarmed until pretrigger filled
// - Code 10 starts with prior programmed setup
// - Start latches setup except the wait limit, which stays live, before running
// - Wait settling delay when relays fitted
// - Code 20 halts immediately in any state
// - Status 0 armed, 10 triggered, 20 stopped
// - Stops itself after post-trigger samples
// - Code 11 starts, interrupt on finish
// - Millisecond timeout ends interrupt wait, zero infinite
// - Data written into memory channels 0 and 1
// - Channel 0 interleaves active channels per sample
// - Sixteen-bit two's complement converter words
// - Four-bit mode: digital in top four
// - Two-bit mode: digital in top two
// - Replace mode: one channel carries sixteen digitals
// - Off mode inserts no digital bits
`timescale 1ns/10ps
`include "arc_map.svh"
module arc_run_control #(
  parameter int AW        = 27,
  parameter int MS_CYCLES = `ARC_MS_NS / `ARC_CLK_NS
) (
  input  wire logic          clk_sys,
  input  wire logic          srst,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [20:0]   s_axi_awaddr,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  output logic      [1:0]    s_axi_bresp,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  input  wire logic [20:0]   s_axi_araddr,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic      [31:0]   s_axi_rdata,
  output logic      [1:0]    s_axi_rresp,
  input  wire logic          adc_valid,
  input  wire logic [63:0]   adc_data,
  input  wire logic [15:0]   dig_in,
  input  wire logic [31:0]   dig_wide,
  input  wire logic          trig_in,
  input  wire logic          relay_fitted,
  output logic               mem0_we,
  output logic      [AW-1:0] mem0_addr,
  output logic      [15:0]   mem0_data,
  output logic               mem1_we,
  output logic      [AW-1:0] mem1_addr,
  output logic      [15:0]   mem1_data,
  output logic               irq
);
  import arc_pkg::*;
  localparam int IW = `ARC_IDX_W;

  if (AW < 27 || AW > 32) begin : g_aw_check
    $error("AW must hold 128M words and fit 32 bits");
  end

  typedef struct packed {
    logic        aw_full;
    logic [20:0] awaddr;
    logic        w_full;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [31:0] cmd;
    logic [31:0] wait_limit;
    logic [31:0] rec_len;
    logic [31:0] post_len;
    logic [1:0]  chan_sel;
    logic [1:0]  dig_mode;
    logic [31:0] settle;
    logic [2:0]  flags;
    arc_state_t  state;
    logic        run_irq;
    logic [1:0]  l_sel;
    logic [1:0]  l_dig;
    logic [31:0] l_rec;
    logic [31:0] l_post;
    logic [31:0] l_pre;
    logic [31:0] l_settle;
    logic [31:0] idx;
    logic [31:0] cnt;
    logic [63:0] words;
    logic [31:0] base;
    logic [1:0]  slot;
    logic [2:0]  slots;
    logic        mem0_we;
    logic [AW-1:0] mem0_addr;
    logic [15:0] mem0_data;
    logic        mem1_we;
    logic [AW-1:0] mem1_addr;
    logic [15:0] mem1_data;
  } arc_main_t;

  arc_main_t st;
  arc_main_t next_st;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [IW-1:0] reg_index(input logic [20:0] addr);
    return addr[20:2];
  endfunction

  function automatic logic [1:0] ch_shift(input logic [1:0] sel);
    return (sel == `ARC_SEL_ALL) ? 2'h2 : ((sel == `ARC_SEL_CH0) ? 2'h0 : 2'h1);
  endfunction

  function automatic logic [1:0] slot_ch(input logic [1:0] sel, input logic [1:0] slot);
    return (sel == `ARC_SEL_CH02) ? {slot[0], 1'b0} : slot;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) res[8*b +: 8] = val[8*b +: 8];
    end
    return res;
  endfunction

  function automatic logic [31:0] status_code(input arc_state_t s);
    unique case (s)
      ARC_IDLE:  return `ARC_STS_STOPPED;
      ARC_POST:  return `ARC_STS_TRIG;
      default:   return `ARC_STS_ARMED;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  logic          wr_fire;
  logic [IW-1:0] widx;
  logic [31:0]   wval;
  logic [63:0]   packed_words;
  logic [1:0]    last_ch;
  logic [1:0]    l_sh;
  logic          tmo_hit;
  logic          post_end;

  assign wr_fire  = st.aw_full && st.w_full && !st.bvalid;
  assign widx     = reg_index(st.awaddr);
  assign wval     = merge(st.cmd, st.wdata, st.wstrb);
  assign l_sh     = ch_shift(st.l_sel);
  assign last_ch  = slot_ch(st.l_sel, 2'((3'h1 << l_sh) - 3'h1));
  assign post_end = (st.state == ARC_POST) && adc_valid && (st.cnt + 32'h1 >= st.l_post);

  genvar c;
  for (c = 0; c < 4; c++) begin : g_pack
    arc_sample_pack u_pack (
      .mode    (st.l_dig),
      .replace (last_ch == 2'(c)),
      .adc     (adc_data[16*c +: 16]),
      .dig     (dig_in[4*c +: 4]),
      .dig16   (dig_wide[15:0]),
      .word    (packed_words[16*c +: 16])
    );
  end

  arc_ms_timer #(.MS_CYCLES(MS_CYCLES)) u_timer (
    .clk_sys (clk_sys),
    .srst    (srst),
    .run     (st.run_irq && st.state != ARC_IDLE),
    .clear   (st.state == ARC_IDLE),
    .limit   (st.wait_limit),
    .expired (tmo_hit)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic        cmd_start;
    logic        cmd_stop;
    logic [2:0]  set_f;
    logic [2:0]  clr_f;
    logic [1:0]  sh;
    logic [31:0] post_c;
    logic [31:0] step_m;
    logic [31:0] min_v;
    cmd_start = 1'b0;
    cmd_stop  = 1'b0;
    set_f     = 3'h0;
    clr_f     = 3'h0;
    sh        = ch_shift(st.chan_sel);
    post_c    = 32'h0;
    step_m    = (`ARC_STEP_ONE >> sh) - 32'h1;
    min_v     = (sh == 2'h0) ? `ARC_MIN_ONE : `ARC_MIN_MULTI;
    next_st   = st;
    next_st.mem0_we = 1'b0;
    next_st.mem1_we = 1'b0;

    if (s_axi_awvalid && !st.aw_full) begin
      next_st.aw_full = 1'b1;
      next_st.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_full) begin
      next_st.w_full = 1'b1;
      next_st.wdata  = s_axi_wdata;
      next_st.wstrb  = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) next_st.bvalid = 1'b0;
    if (wr_fire) begin
      next_st.aw_full = 1'b0;
      next_st.w_full  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = `ARC_RESP_OKAY;
      unique case (widx)
        `ARC_IDX_COMMAND: begin
          next_st.cmd = wval;
          cmd_start = (wval == `ARC_CMD_START) || (wval == `ARC_CMD_START_IRQ);
          cmd_stop  = (wval == `ARC_CMD_STOP);
        end
        `ARC_IDX_WAIT_MS:   next_st.wait_limit = merge(st.wait_limit, st.wdata, st.wstrb);
        `ARC_IDX_REC_LEN:   next_st.rec_len = merge(st.rec_len, st.wdata, st.wstrb);
        `ARC_IDX_POST:      next_st.post_len = merge(st.post_len, st.wdata, st.wstrb);
        `ARC_IDX_SETTLE:    next_st.settle = merge(st.settle, st.wdata, st.wstrb);
        `ARC_IDX_CHAN_SEL:  if (st.wstrb[0]) next_st.chan_sel = st.wdata[1:0];
        `ARC_IDX_DIG_MODE:  if (st.wstrb[0]) next_st.dig_mode = st.wdata[1:0];
        `ARC_IDX_FLAGS:     if (st.wstrb[0]) clr_f = st.wdata[2:0];
        `ARC_IDX_RUN_STATE: next_st.bresp = `ARC_RESP_OKAY;
        default:            next_st.bresp = `ARC_RESP_SLVERR;
      endcase
    end

    if (st.rvalid && s_axi_rready) next_st.rvalid = 1'b0;
    if (s_axi_arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = `ARC_RESP_OKAY;
      unique case (reg_index(s_axi_araddr))
        `ARC_IDX_COMMAND:   next_st.rdata = st.cmd;
        `ARC_IDX_RUN_STATE: next_st.rdata = status_code(st.state);
        `ARC_IDX_WAIT_MS:   next_st.rdata = st.wait_limit;
        `ARC_IDX_REC_LEN:   next_st.rdata = st.rec_len;
        `ARC_IDX_POST:      next_st.rdata = st.post_len;
        `ARC_IDX_SETTLE:    next_st.rdata = st.settle;
        `ARC_IDX_CHAN_SEL:  next_st.rdata = {30'h0, st.chan_sel};
        `ARC_IDX_DIG_MODE:  next_st.rdata = {30'h0, st.dig_mode};
        `ARC_IDX_FLAGS:     next_st.rdata = {29'h0, st.flags};
        default: begin
          next_st.rdata = 32'h0;
          next_st.rresp = `ARC_RESP_SLVERR;
        end
      endcase
    end

    // Slot drain, one word per cycle
    if (st.slots != 3'h0) begin
      next_st.mem0_we   = 1'b1;
      next_st.mem0_addr = AW'(st.base + {30'h0, st.slot});
      next_st.mem0_data = st.words[16*slot_ch(st.l_sel, st.slot) +: 16];
      next_st.slot      = st.slot + 2'h1;
      next_st.slots     = st.slots - 3'h1;
    end

    // Accept one sample set per converter strobe
    if (adc_valid && (st.state inside {ARC_FILL, ARC_ARMED, ARC_POST})) begin
      next_st.words = packed_words;
      next_st.slot  = 2'h0;
      next_st.slots = 3'(3'h1 << l_sh);
      next_st.base  = st.idx << l_sh;
      next_st.idx   = (st.idx + 32'h1 >= st.l_rec) ? 32'h0 : st.idx + 32'h1;
      // Second digital group to channel 1
      if (st.l_dig == `ARC_DIG_REPLACE) begin
        next_st.mem1_we   = 1'b1;
        next_st.mem1_addr = AW'(st.idx);
        next_st.mem1_data = dig_wide[31:16];
      end
    end

    unique case (st.state)
      ARC_SETTLE: begin
        next_st.cnt = st.cnt + 32'h1;
        if (st.cnt + 32'h1 >= st.l_settle) begin
          next_st.cnt   = 32'h0;
          next_st.state = (st.l_pre == 32'h0) ? ARC_ARMED : ARC_FILL;
        end
      end
      ARC_FILL: begin
        if (adc_valid) begin
          next_st.cnt = st.cnt + 32'h1;
          if (st.cnt + 32'h1 >= st.l_pre) next_st.state = ARC_ARMED;
        end
      end
      ARC_ARMED: begin
        if (trig_in) begin
          next_st.state = ARC_POST;
          next_st.cnt   = 32'h0;
        end
      end
      ARC_POST: begin
        if (adc_valid) next_st.cnt = st.cnt + 32'h1;
        if (post_end) begin
          next_st.state = ARC_IDLE;
          if (st.run_irq) set_f = set_f | `ARC_FLAG_DONE;
        end
      end
      ARC_IDLE: begin
        if (cmd_start) begin
          // Clip post count per channel count
          post_c = (st.post_len > (`ARC_POST_MAX_ONE >> sh)) ?
                   (`ARC_POST_MAX_ONE >> sh) : st.post_len;
          next_st.l_sel    = st.chan_sel;
          next_st.l_dig    = st.dig_mode;
          next_st.l_rec    = st.rec_len;
          next_st.l_post   = post_c;
          next_st.l_pre    = (st.rec_len > post_c) ? st.rec_len - post_c : 32'h0;
          next_st.l_settle = st.settle;
          next_st.run_irq  = (wval == `ARC_CMD_START_IRQ);
          next_st.idx      = 32'h0;
          next_st.cnt      = 32'h0;
          next_st.slots    = 3'h0;
          if (relay_fitted && st.settle != 32'h0) next_st.state = ARC_SETTLE;
          else if (st.rec_len <= post_c)            next_st.state = ARC_ARMED;
          else                                      next_st.state = ARC_FILL;
          if (st.rec_len < min_v || st.post_len < min_v ||
              (st.rec_len & step_m) != 32'h0 || (st.post_len & step_m) != 32'h0) begin
            set_f = set_f | `ARC_FLAG_SETUP;
          end
        end
      end
      default: next_st.state = ARC_IDLE;
    endcase

    // Timeout ends the wait with error
    if (tmo_hit && st.state != ARC_IDLE) begin
      next_st.state = ARC_IDLE;
      next_st.slots = 3'h0;
      set_f = set_f | `ARC_FLAG_DONE | `ARC_FLAG_TIMEOUT;
    end
    // Stop overrides everything except same-cycle done and timeout flags, pending words dropped
    if (cmd_stop) begin
      next_st.state   = ARC_IDLE;
      next_st.slots   = 3'h0;
      next_st.mem0_we = 1'b0;
      next_st.mem1_we = 1'b0;
    end
    // Set wins over a same-cycle clear
    next_st.flags = (st.flags & ~clr_f) | set_f;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) st <= '0;
    else      st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign s_axi_awready = !st.aw_full;
  assign s_axi_wready  = !st.w_full;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign mem0_we       = st.mem0_we;
  assign mem0_addr     = st.mem0_addr;
  assign mem0_data     = st.mem0_data;
  assign mem1_we       = st.mem1_we;
  assign mem1_addr     = st.mem1_addr;
  assign mem1_data     = st.mem1_data;
  // Done and timeout raise the line; setup warning is poll-only
  assign irq           = |(st.flags & (`ARC_FLAG_DONE | `ARC_FLAG_TIMEOUT));

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  property p_stop;
    wr_fire && widx == `ARC_IDX_COMMAND && wval == `ARC_CMD_STOP
      |=> st.state == ARC_IDLE && !mem0_we ##1 !mem0_we;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not halt");

  property p_ignore;
    wr_fire && widx == `ARC_IDX_COMMAND && wval == `ARC_CMD_START && st.state != ARC_IDLE
      |=> $stable(st.l_rec) && $stable(st.l_post);
  endproperty
  a_ignore: assert property (p_ignore) else $error("start while running changed setup");

  property p_latch;
    wr_fire && widx == `ARC_IDX_COMMAND && wval == `ARC_CMD_START && st.state == ARC_IDLE
      |=> st.l_rec == $past(st.rec_len) && st.state != ARC_IDLE && !st.run_irq;
  endproperty
  a_latch: assert property (p_latch) else $error("setup not latched on start");

  property p_cap;
    st.state != ARC_IDLE |-> st.l_post <= (`ARC_POST_MAX_ONE >> l_sh);
  endproperty
  a_cap: assert property (p_cap) else $error("post count above limit");

  property p_pre;
    st.state != ARC_IDLE |-> st.l_pre == ((st.l_rec > st.l_post) ? st.l_rec - st.l_post : 32'h0);
  endproperty
  a_pre: assert property (p_pre) else $error("pretrigger size wrong");

  property p_disarm;
    st.state == ARC_FILL |=> st.state != ARC_POST && (st.state != ARC_ARMED || st.cnt == st.l_pre);
  endproperty
  a_disarm: assert property (p_disarm) else $error("trigger taken during fill");

  property p_auto;
    post_end && st.run_irq |=> st.state == ARC_IDLE && irq &&
      ($past(s_axi_arvalid && s_axi_arready) || s_axi_rdata == $past(s_axi_rdata));
  endproperty
  a_auto: assert property (p_auto) else $error("no self stop with interrupt");

  property p_status;
    s_axi_arvalid && s_axi_arready && reg_index(s_axi_araddr) == `ARC_IDX_RUN_STATE
      |=> s_axi_rdata == (($past(st.state) == ARC_IDLE) ? `ARC_STS_STOPPED :
                          (($past(st.state) == ARC_POST) ? `ARC_STS_TRIG : `ARC_STS_ARMED));
  endproperty
  a_status: assert property (p_status) else $error("status code mismatch");

  property p_tmo;
    tmo_hit && st.state != ARC_IDLE |=> st.state == ARC_IDLE && st.flags[1] && irq;
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout did not end run");

  property p_four;
    st.l_dig == `ARC_DIG_FOUR |-> packed_words[15:0] == {dig_in[3:0], adc_data[15:4]};
  endproperty
  a_four: assert property (p_four) else $error("four-bit packing wrong");

  property p_two;
    st.l_dig == `ARC_DIG_TWO |-> packed_words[31:16] == {dig_in[5:4], adc_data[31:18]};
  endproperty
  a_two: assert property (p_two) else $error("two-bit packing wrong");

  c_trig: cover property (st.state == ARC_ARMED ##1 st.state == ARC_POST);
  c_done: cover property (post_end ##1 st.state == ARC_IDLE);
  c_tmo:  cover property (tmo_hit && st.state != ARC_IDLE);
endmodule // arc_run_control

// File: verilog/arc_sample_pack.sv
// Packs one converter sample with its digital inputs into a 16-bit word
`timescale 1ns/10ps
`include "arc_map.svh"
module arc_sample_pack (
  input  wire arc_pkg::arc_dig_t mode,
  input  wire logic              replace,
  input  wire logic [15:0]       adc,
  input  wire logic [3:0]        dig,
  input  wire logic [15:0]       dig16,
  output logic      [15:0]       word
);
  import arc_pkg::*;
  always_comb begin
    unique case (mode)
      `ARC_DIG_FOUR:    word = {dig[3:0], adc[15:4]};
      `ARC_DIG_TWO:     word = {dig[1:0], adc[15:2]};
      `ARC_DIG_REPLACE: word = replace ? dig16 : adc;
      default:          word = adc;
    endcase
  end
endmodule // arc_sample_pack
